// ---- sram_port_map.svh ----
// Purpose: Named constants for the pipelined burst SRAM port.
// Assumes: Included by bare name from the design file.
// Notes: Widths are the x36 organisation, four 9-bit lanes.
`ifndef SRAM_PORT_MAP_SVH
`define SRAM_PORT_MAP_SVH

// Array geometry
`define MEM_AW 18
`define MEM_DW 36
`define LANES 4
`define LANE_W 9
`define LANES_ALL 4'hf
`define LANES_NONE 4'h0

// Burst counter
`define BURST_W 2
`define BURST_STEP 2'h1
`define BURST_FIRST 2'h0
`define BURST_LAST 2'h3

// Write buffer
`define WBUF_DEPTH 4
`define WBUF_W (`MEM_AW + `MEM_DW + `LANES)

`endif

// ---- sram_port_pkg.sv ----
// Purpose: Types shared by the SRAM port design.
// Assumes: Constants live in sram_port_map.svh.
// Notes: State codes are one-hot.
package sram_port_pkg;

  // Access state of the port
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h1,
    ST_ACTIVE = 3'h2,
    ST_SLEEP  = 3'h4
  } state_t;

  // Burst order chosen by the strap
  typedef enum logic {
    ORDER_LINEAR     = 1'b0,
    ORDER_INTERLEAVE = 1'b1
  } burst_order_t;

endpackage : sram_port_pkg

// ---- sram_port.sv ----
// Purpose: Pipelined burst SRAM port: input regs, burst counter, writes, sleep.
// Assumes: Bus master shares i_sys_clk; OE, sleep, strap and scan pins are async.
// Notes: Writes pass a small buffer before the array; reads forward from its head.
// Behaviour
// - All synchronous inputs are captured in input registers at the rising edge.
// - Read data is launched from the output register one rise after acceptance.
// - Read starts on either strobe, all selects active, no write; CE1 high masks PROCESSOR_ADDR_STROBE_N.
// - A new access loads its address into address register and burst logic.
// - Outputs float during the first cycle when leaving the deselected state.
// - After the first cycle, read data drives only with output enable low and no write, deselect or sleep.
// - A deselecting strobe floats the data outputs at once.
// - Processor-strobe start ignores write controls and advance, captures address only.
// - Processor-strobe write completes at the second rise; global write stores all.
// - Byte writes store only lanes selected with byte write enable.
// - Global write overrides byte enables and stores every lane.
// - Controller strobe with selects and write controls writes in one cycle.
// - Controller-strobe write start ignores advance and loads the address.
// - Any detected write forces the data pins to float.
// - Two-bit wrapping burst counter from A1:A0, order set by strap.
// - Advance low steps the counter, for reads and writes alike.
// - Sleep is asynchronous, enters low power and retains array contents.
// - Entering and leaving sleep each take two clock cycles.
// - An access pending at sleep entry is dropped as invalid.
// - Scan data and mode inputs are sampled on the test clock rise.
// - Strap low selects linear order, high or floating selects interleaved.
// - Interleaved XORs start bits with step; linear adds step modulo four.
// - Write is true on global write, or byte enable with any lane selected.
`timescale 1ns/1ns
`include "sram_port_map.svh"

// Small first-in first-out buffer built from flip-flops
module sram_port_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Fill side
  input wire logic i_push_valid,
  output logic o_push_ready,
  input wire logic [WIDTH-1:0] i_push_data,
  // Drain side
  output logic o_pop_valid,
  input wire logic i_pop_ready,
  output logic [WIDTH-1:0] o_pop_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] slot_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0] count_reg;
  logic push_fire;
  logic pop_fire;

  // Handshakes; full and empty come from the occupancy count
  assign o_push_ready = (count_reg != DEPTH[PW:0]);
  assign o_pop_valid = (count_reg != '0);
  assign o_pop_data = slot_reg[rd_ptr_reg];
  assign push_fire = i_push_valid && o_push_ready;
  assign pop_fire = o_pop_valid && i_pop_ready;

  // Pointer wrap for any depth
  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction : bump

  // Storage, no reset needed for data
  always_ff @(posedge i_clk) begin
    if (push_fire) begin
      slot_reg[wr_ptr_reg] <= i_push_data;
    end
  end

  // Pointers and count
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push_fire) begin
        wr_ptr_reg <= bump(wr_ptr_reg);
      end
      if (pop_fire) begin
        rd_ptr_reg <= bump(rd_ptr_reg);
      end
      if (push_fire && !pop_fire) begin
        count_reg <= count_reg + (PW+1)'(1);
      end else if (pop_fire && !push_fire) begin
        count_reg <= count_reg - (PW+1)'(1);
      end
    end
  end
endmodule : sram_port_fifo

// Memory-side port of the burst SRAM
module sram_port
  import sram_port_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Address and chip selects
  input wire logic [`MEM_AW-1:0] i_addr,
  input wire logic i_chip_sel1_n,
  input wire logic i_chip_sel2,
  input wire logic i_chip_sel3_n,
  // Address strobes and advance
  input wire logic i_processor_addr_strobe_n,
  input wire logic i_controller_addr_strobe_n,
  input wire logic i_burst_advance_n,
  // Write controls
  input wire logic i_global_write_n,
  input wire logic i_byte_write_enable_n,
  input wire logic [`LANES-1:0] i_byte_lane_select_n,
  // Data pins, parity_io bits are the top bit of each lane
  input wire logic [`MEM_DW-1:0] i_data_in,
  output logic [`MEM_DW-1:0] o_data_out,
  output logic o_data_oe,
  // Asynchronous pins
  input wire logic i_output_enable_n,
  input wire logic i_sleep_request,
  input wire logic i_burst_order,
  // Status
  output logic o_sleep_active,
  output logic o_write_ready,
  // Boundary-scan sampling
  input wire logic i_scan_tck,
  input wire logic i_scan_tdi,
  input wire logic i_scan_tms,
  output logic o_scan_tdi_sample,
  output logic o_scan_tms_sample
);

  // Input registers
  logic [`MEM_AW-1:0] addr_in_reg;
  logic cs1_n_reg, cs2_reg, cs3_n_reg;
  logic processor_addr_strobe_n_n_reg, controller_addr_strobe_n_n_reg, adv_n_reg;
  logic gw_n_reg, bwe_n_reg;
  logic [`LANES-1:0] bw_n_reg;
  logic [`MEM_DW-1:0] data_in_reg;

  // Synchronisers: stage 1 feeds stage 2 only
  logic oe_n_s1, oe_n_s2, sleep_s1, sleep_s2, order_s1, order_s2;
  logic tck_s1, tck_s2, tck_s3, tdi_s1, tdi_s2, tms_s1, tms_s2;

  // Access state
  state_t state_reg;
  logic [`MEM_AW-1:0] base_reg;
  logic [`BURST_W-1:0] count_reg;
  logic drive_reg;
  logic [`MEM_DW-1:0] out_data_reg;
  logic [`MEM_DW-1:0] mem [2**`MEM_AW];

  // Decode
  logic sel, processor_addr_strobe_n_hit, controller_addr_strobe_n_hit, strobe, write_any, awake;
  logic new_acc, desel_hit, cont, first_cyc, wr_fire, rd_fire;
  logic [`BURST_W-1:0] count_cur;
  logic [`MEM_AW-1:0] acc_addr;
  logic [`LANES-1:0] lane_mask;
  logic [`MEM_DW-1:0] rd_word;
  burst_order_t order;

  // Write buffer
  logic wbuf_ready, head_valid;
  logic [`WBUF_W-1:0] head;
  logic [`MEM_AW-1:0] head_addr;
  logic [`MEM_DW-1:0] head_data;
  logic [`LANES-1:0] head_mask;

  // Burst address low bits for a given step count
  function automatic logic [`BURST_W-1:0] burst_low(input logic [`BURST_W-1:0] first,
      input logic [`BURST_W-1:0] step, input burst_order_t ord);
    burst_low = (ord == ORDER_INTERLEAVE) ? (first ^ step) : (first + step);
  endfunction : burst_low

  // Merge lanes of a new word over an old one
  function automatic logic [`MEM_DW-1:0] merge(input logic [`MEM_DW-1:0] old_w,
      input logic [`MEM_DW-1:0] new_w, input logic [`LANES-1:0] mask);
    merge = old_w;
    for (int i = 0; i < `LANES; i++) begin
      if (mask[i]) begin
        merge[i*`LANE_W +: `LANE_W] = new_w[i*`LANE_W +: `LANE_W];
      end
    end
  endfunction : merge

  // Every synchronous pin is registered before use
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      addr_in_reg <= '0;
      cs1_n_reg <= 1'b1;
      cs2_reg <= 1'b0;
      cs3_n_reg <= 1'b1;
      processor_addr_strobe_n_n_reg <= 1'b1;
      controller_addr_strobe_n_n_reg <= 1'b1;
      adv_n_reg <= 1'b1;
      gw_n_reg <= 1'b1;
      bwe_n_reg <= 1'b1;
      bw_n_reg <= `LANES_ALL;
      data_in_reg <= '0;
    end else begin
      addr_in_reg <= i_addr;
      cs1_n_reg <= i_chip_sel1_n;
      cs2_reg <= i_chip_sel2;
      cs3_n_reg <= i_chip_sel3_n;
      processor_addr_strobe_n_n_reg <= i_processor_addr_strobe_n;
      controller_addr_strobe_n_n_reg <= i_controller_addr_strobe_n;
      adv_n_reg <= i_burst_advance_n;
      gw_n_reg <= i_global_write_n;
      bwe_n_reg <= i_byte_write_enable_n;
      bw_n_reg <= i_byte_lane_select_n;
      data_in_reg <= i_data_in;
    end
  end

  // Async pins; sleep sync gives the two-cycle entry and exit
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      oe_n_s1 <= 1'b1;
      oe_n_s2 <= 1'b1;
      sleep_s1 <= 1'b0;
      sleep_s2 <= 1'b0;
      order_s1 <= 1'b1;
      order_s2 <= 1'b1;
    end else begin
      oe_n_s1 <= i_output_enable_n;
      oe_n_s2 <= oe_n_s1;
      sleep_s1 <= i_sleep_request;
      sleep_s2 <= sleep_s1;
      order_s1 <= i_burst_order;
      order_s2 <= order_s1;
    end
  end

  // Strap high or pulled up means interleaved; static in use
  assign order = order_s2 ? ORDER_INTERLEAVE : ORDER_LINEAR;
  assign o_sleep_active = sleep_s2;

  // Cycle decode from the registered pins
  always_comb begin
    sel = !cs1_n_reg && cs2_reg && !cs3_n_reg;
    processor_addr_strobe_n_hit = !processor_addr_strobe_n_n_reg && !cs1_n_reg;
    controller_addr_strobe_n_hit = !controller_addr_strobe_n_n_reg;
    strobe = processor_addr_strobe_n_hit || controller_addr_strobe_n_hit;
    write_any = !gw_n_reg || (!bwe_n_reg && (bw_n_reg != `LANES_ALL));
    awake = (state_reg != ST_SLEEP) && !sleep_s2;
    new_acc = awake && strobe && sel;
    desel_hit = awake && strobe && !sel;
    cont = awake && !strobe && (state_reg == ST_ACTIVE);
    first_cyc = new_acc && (state_reg != ST_ACTIVE);
    // Advance only counts on continuing cycles, never on a start
    if (cont && !adv_n_reg) begin
      count_cur = count_reg + `BURST_STEP;
    end else if (new_acc) begin
      count_cur = `BURST_FIRST;
    end else begin
      count_cur = count_reg;
    end
    acc_addr = new_acc ? addr_in_reg
      : {base_reg[`MEM_AW-1:`BURST_W], burst_low(base_reg[`BURST_W-1:0], count_cur, order)};
    // Processor-strobe start is always a read-type first cycle
    wr_fire = write_any && ((new_acc && !processor_addr_strobe_n_hit) || cont);
    rd_fire = (new_acc && (processor_addr_strobe_n_hit || !write_any)) || (cont && !write_any);
    lane_mask = !gw_n_reg ? `LANES_ALL
      : (!bwe_n_reg ? ~bw_n_reg : `LANES_NONE);
  end

  // State; sleep drops any access in flight
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= ST_IDLE;
    end else if (sleep_s2) begin
      state_reg <= ST_SLEEP;
    end else if (new_acc) begin
      state_reg <= ST_ACTIVE;
    end else if (desel_hit || (state_reg == ST_SLEEP)) begin
      state_reg <= ST_IDLE;
    end
  end

  // Address register and burst counter
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      base_reg <= '0;
      count_reg <= `BURST_FIRST;
    end else begin
      if (new_acc) begin
        base_reg <= addr_in_reg;
      end
      count_reg <= count_cur;
    end
  end

  // Write buffer: drain stalls while asleep, contents kept
  assign head_addr = head[`WBUF_W-1 -: `MEM_AW];
  assign head_data = head[`LANES +: `MEM_DW];
  assign head_mask = head[`LANES-1:0];
  assign o_write_ready = wbuf_ready;

  sram_port_fifo #(
    .WIDTH(`WBUF_W),
    .DEPTH(`WBUF_DEPTH)
  ) u_wbuf (
    .i_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_push_valid(wr_fire),
    .o_push_ready(wbuf_ready),
    .i_push_data({acc_addr, data_in_reg, lane_mask}),
    .o_pop_valid(head_valid),
    .i_pop_ready(!sleep_s2),
    .o_pop_data(head)
  );

  // Array update, unselected lanes untouched
  always_ff @(posedge i_sys_clk) begin
    if (head_valid && !sleep_s2) begin
      mem[head_addr] <= merge(mem[head_addr], head_data, head_mask);
    end
  end

  // Read forwards the write still waiting at the buffer head
  assign rd_word = (head_valid && (head_addr == acc_addr))
    ? merge(mem[acc_addr], head_data, head_mask) : mem[acc_addr];

  // Output register, launched one rise after acceptance
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      drive_reg <= 1'b0;
      out_data_reg <= '0;
    end else begin
      drive_reg <= rd_fire;
      if (rd_fire) begin
        out_data_reg <= rd_word;
      end
    end
  end

  // Pin drive; OE is synchronised, so it lags the pin by two cycles
  assign o_data_out = out_data_reg;
  assign o_data_oe = drive_reg && !oe_n_s2
    && !wr_fire
    && !desel_hit
    && !first_cyc
    && !sleep_s2;

  // Scan pins sampled on a rising test clock
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      tck_s1 <= 1'b0;
      tck_s2 <= 1'b0;
      tck_s3 <= 1'b0;
      tdi_s1 <= 1'b1;
      tdi_s2 <= 1'b1;
      tms_s1 <= 1'b1;
      tms_s2 <= 1'b1;
      o_scan_tdi_sample <= 1'b1;
      o_scan_tms_sample <= 1'b1;
    end else begin
      tck_s1 <= i_scan_tck;
      tck_s2 <= tck_s1;
      tck_s3 <= tck_s2;
      tdi_s1 <= i_scan_tdi;
      tdi_s2 <= tdi_s1;
      tms_s1 <= i_scan_tms;
      tms_s2 <= tms_s1;
      if (tck_s2 && !tck_s3) begin
        o_scan_tdi_sample <= tdi_s2;
        o_scan_tms_sample <= tms_s2;
      end
    end
  end

  // Checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  sequence s_sleep_held;
    i_sleep_request [*3];
  endsequence

  sequence s_step_at_end;
    cont && !adv_n_reg && (count_reg == `BURST_LAST);
  endsequence

  a_read_latency: assert property (rd_fire |=> drive_reg && (out_data_reg == $past(rd_word)))
    else $error("read word not launched one rise later");
  a_deselect_float: assert property (desel_hit |-> !o_data_oe)
    else $error("outputs driven on deselect");
  a_write_float: assert property (wr_fire |-> !o_data_oe)
    else $error("outputs driven during write");
  a_first_float: assert property (first_cyc |-> !o_data_oe ##1 (state_reg == ST_ACTIVE))
    else $error("first cycle not floated");
  a_burst_wrap: assert property (s_step_at_end |=> count_reg == `BURST_FIRST)
    else $error("burst counter failed to wrap");
  a_burst_hold: assert property (cont && adv_n_reg |=> $stable(count_reg))
    else $error("burst address moved on suspend");
  a_sleep_entry: assert property (s_sleep_held |-> o_sleep_active ##1 (state_reg == ST_SLEEP))
    else $error("sleep not entered in two cycles");
  a_global_lanes: assert property (wr_fire && !gw_n_reg |-> lane_mask == `LANES_ALL)
    else $error("global write missed a lane");
  a_processor_addr_strobe_n_ignore: assert property (new_acc && processor_addr_strobe_n_hit |-> !wr_fire && rd_fire)
    else $error("processor strobe start wrote");
  a_controller_addr_strobe_n_write: assert property (new_acc && !processor_addr_strobe_n_hit && write_any |-> wr_fire && (acc_addr == addr_in_reg))
    else $error("controller strobe write not taken");
  a_sleep_drop: assert property (o_sleep_active |=> (state_reg == ST_SLEEP) && !drive_reg)
    else $error("access survived sleep");
  a_addr_load: assert property (new_acc |=> base_reg == $past(addr_in_reg) && count_reg == `BURST_FIRST)
    else $error("start address not loaded");

endmodule : sram_port

// ---- sram_bus_master.sv ----
// Purpose: Bus master model driving the SRAM port pins.
// Assumes: Pins change just after the falling edge of i_clk.
// Notes: Released data lines show the inverse of the last word.
`timescale 1ns/1ns
`include "sram_port_map.svh"

module sram_bus_master
  import sram_port_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Synchronous pins
  output logic [`MEM_AW-1:0] o_addr,
  output logic o_sel1_n,
  output logic o_sel2,
  output logic o_sel3_n,
  output logic o_pstrobe_n,
  output logic o_cstrobe_n,
  output logic o_step_n,
  output logic o_gwrite_n,
  output logic o_bwrite_n,
  output logic [`LANES-1:0] o_lane_n,
  output logic [`MEM_DW-1:0] o_data,
  // Asynchronous pins
  output logic o_oe_n,
  output logic o_sleep
);
  // Quiet bus at time zero
  initial begin
    {o_sel1_n, o_sel2, o_sel3_n} = 3'h5;
    {o_pstrobe_n, o_cstrobe_n, o_step_n, o_gwrite_n, o_bwrite_n} = 5'h1f;
    o_lane_n = 4'hf;
    o_addr = 18'h0;
    o_data = 36'h0;
    o_oe_n = 1'h1;
    o_sleep = 1'h0;
  end

  // One bus cycle; a stale word would hide a missed capture
  task automatic pins(input logic [4:0] ctl, input logic [3:0] lane_n,
                      input logic [17:0] a, input logic [35:0] d, input logic wr,
                      input logic sel);
    @(negedge i_clk);
    {o_pstrobe_n, o_cstrobe_n, o_step_n, o_gwrite_n, o_bwrite_n} = ctl;
    o_lane_n = lane_n;
    o_addr = a;
    {o_sel1_n, o_sel2, o_sel3_n} = sel ? 3'h2 : 3'h5;
    o_data = wr ? d : ~o_data;
  endtask : pins

  // Output enable is raised before write data; waits out the sync lag
  task automatic set_oe(input logic oe_n);
    @(negedge i_clk);
    o_oe_n = oe_n;
    repeat (3) @(negedge i_clk);
  endtask : set_oe

  // Sleep pin moves only while the port is deselected
  task automatic sleep(input logic on);
    pins(5'h1f, 4'hf, o_addr, 36'h0, 1'h0, 1'h0);
    o_sleep = on;
  endtask : sleep
endmodule : sram_bus_master

// ---- pipelined_burst_sram_port_tb.sv ----
// Purpose: Self-checking bench for the burst SRAM port and its buffer.
// Assumes: Inputs change at the falling edge; 4 ns clock.
// Notes: Reads are checked at the falling edge after the launch edge.
`timescale 1ns/1ns
`include "sram_port_map.svh"
`define CHK(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); \
    end \
  end

module pipelined_burst_sram_port_tb
  import sram_port_pkg::*;
;
  localparam logic [4:0] C_IDLE = 5'h1f;
  localparam logic [4:0] C_RD = 5'h17;
  localparam logic [4:0] C_WRG = 5'h15;
  localparam logic [4:0] C_PST = 5'h09;
  localparam logic [4:0] C_WB2 = 5'h1e;
  localparam logic [4:0] C_WGB = 5'h1c;
  localparam logic [4:0] C_STEP = 5'h1b;
  int miscompares = 0;
  int tests_run = 0;
  logic sys_clk, rst, strap, tck, tdi, tms, sel1_n, sel2, sel3_n, pst_n, cst_n, step_n;
  logic gw_n, bw_n, oe_n, slp, data_oe, slp_act, wr_rdy, tdi_s, tms_s;
  logic [3:0] lane_n;
  logic [`MEM_AW-1:0] addr;
  logic [`MEM_DW-1:0] din, data_out;

  // Clock
  always #2 sys_clk = ~sys_clk;

  sram_bus_master mst_u (.i_clk(sys_clk), .o_addr(addr), .o_sel1_n(sel1_n), .o_sel2(sel2),
    .o_sel3_n(sel3_n), .o_pstrobe_n(pst_n), .o_cstrobe_n(cst_n), .o_step_n(step_n),
    .o_gwrite_n(gw_n), .o_bwrite_n(bw_n), .o_lane_n(lane_n), .o_data(din), .o_oe_n(oe_n),
    .o_sleep(slp));

  sram_port dut_u (.i_sys_clk(sys_clk), .i_rst(rst), .i_addr(addr), .i_chip_sel1_n(sel1_n),
    .i_chip_sel2(sel2), .i_chip_sel3_n(sel3_n), .i_processor_addr_strobe_n(pst_n),
    .i_controller_addr_strobe_n(cst_n), .i_burst_advance_n(step_n), .i_global_write_n(gw_n),
    .i_byte_write_enable_n(bw_n), .i_byte_lane_select_n(lane_n), .i_data_in(din),
    .o_data_out(data_out), .o_data_oe(data_oe), .i_output_enable_n(oe_n),
    .i_sleep_request(slp), .i_burst_order(strap), .o_sleep_active(slp_act),
    .o_write_ready(wr_rdy), .i_scan_tck(tck), .i_scan_tdi(tdi), .i_scan_tms(tms),
    .o_scan_tdi_sample(tdi_s), .o_scan_tms_sample(tms_s));

  // Distinct word per address
  function automatic logic [35:0] wv(input logic [17:0] a);
    return {a, a};
  endfunction : wv

  task automatic cyc(input logic [4:0] c, input logic [17:0] a, input logic [35:0] d,
                     input logic [3:0] ln = 4'hf, input logic sel = 1'h1);
    mst_u.pins(c, ln, a, d, c[1:0] != 2'h3, sel);
  endtask : cyc

  task automatic rd_chk(input logic [17:0] a, input logic [35:0] e);
    cyc(C_RD, a, 36'h0);
    cyc(C_IDLE, a, 36'h0);
    cyc(C_IDLE, a, 36'h0);
    `CHK(data_out, e)
  endtask : rd_chk

  // Write buffer seen through the port: drains as fast as writes arrive
  task automatic t_fifo();
    `CHK(wr_rdy, 1'h1)
    mst_u.set_oe(1'h1);
    for (int i = 0; i < 4; i++) begin
      cyc(C_WRG, 18'h300 + 18'(i), wv(18'h300 + 18'(i)));
      `CHK(wr_rdy, 1'h1)
    end
    mst_u.set_oe(1'h0);
    rd_chk(18'h303, wv(18'h303));
    rd_chk(18'h300, wv(18'h300));
    `CHK(wr_rdy, 1'h1)
  endtask : t_fifo

  task automatic t_scan();
    tdi = 1'h0;
    tms = 1'h1;
    repeat (3) @(negedge sys_clk);
    tck = 1'h1;
    repeat (6) @(negedge sys_clk);
    `CHK({tdi_s, tms_s}, 2'h1)
    tck = 1'h0;
  endtask : t_scan

  // Back-to-back reads, then a deselect floats the pins at once
  task automatic t_basic();
    mst_u.set_oe(1'h1);
    for (int i = 0; i < 4; i++) begin
      cyc(C_WRG, 18'h100 + 18'(i), wv(18'h100 + 18'(i)));
    end
    mst_u.set_oe(1'h0);
    cyc(C_RD, 18'h101, 36'h0);
    cyc(C_RD, 18'h102, 36'h0);
    cyc(C_RD, 18'h0, 36'h0, 4'hf, 1'h0);
    `CHK({data_oe, data_out}, {1'h1, wv(18'h101)})
    cyc(C_IDLE, 18'h0, 36'h0);
    `CHK({data_oe, data_out}, {1'h0, wv(18'h102)})
  endtask : t_basic

  // Two-cycle writes with byte and global control, and a non-write
  task automatic t_bytes();
    logic [35:0] w;
    w = wv(18'h101);
    mst_u.set_oe(1'h1);
    cyc(C_PST, 18'h101, 36'h0);
    cyc(C_WB2, 18'h3, 36'hf_ffff_ffff, 4'hd);
    cyc(C_PST, 18'h102, 36'h0);
    cyc(C_WGB, 18'h3, 36'h5_5555_5555, 4'he);
    cyc(C_RD, 18'h103, 36'h0, 4'h0);
    mst_u.set_oe(1'h0);
    rd_chk(18'h101, {w[35:18], 9'h1ff, w[8:0]});
    rd_chk(18'h102, 36'h5_5555_5555);
    rd_chk(18'h103, wv(18'h103));
  endtask : t_bytes

  // Four-beat burst from offset 1, then a held beat
  task automatic t_burst(input logic ord);
    int s;
    logic [1:0] j;
    mst_u.set_oe(1'h1);
    for (int i = 0; i < 4; i++) begin
      cyc(C_WRG, 18'h200 + 18'(i), wv(18'h200 + 18'(i)));
    end
    strap = ord;
    mst_u.set_oe(1'h0);
    cyc(C_RD, 18'h201, 36'h0);
    for (int k = 0; k < 6; k++) begin
      cyc(k < 3 ? C_STEP : C_IDLE, 18'h0, 36'h0);
      s = (k > 4) ? 3 : k - 1;
      j = ord ? (2'h1 ^ 2'(s)) : (2'h1 + 2'(s));
      if (k > 0) begin
        `CHK(data_out, wv({16'h80, j}))
      end
    end
  endtask : t_burst

  // Sleep entry and exit timing; contents survive
  task automatic t_sleep();
    mst_u.sleep(1'h1);
    @(negedge sys_clk);
    `CHK(slp_act, 1'h0)
    @(negedge sys_clk);
    `CHK(slp_act, 1'h1)
    mst_u.sleep(1'h0);
    repeat (2) @(negedge sys_clk);
    `CHK(slp_act, 1'h0)
    repeat (4) cyc(C_IDLE, 18'h0, 36'h0, 4'hf, 1'h0);
    rd_chk(18'h203, wv(18'h203));
  endtask : t_sleep

  task automatic tally_and_finish();
    if (miscompares == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  // Whole run is about 120 cycles; allow ample margin
  initial begin
    #20000;
    miscompares++;
    tally_and_finish();
  end

  // Reset, then the scenarios
  initial begin
    sys_clk = 1'h0;
    rst = 1'h1;
    strap = 1'h1;
    tck = 1'h0;
    tdi = 1'h1;
    tms = 1'h0;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'h0;
    t_fifo();
    t_scan();
    t_basic();
    t_bytes();
    t_burst(1'h1);
    t_burst(1'h0);
    t_sleep();
    tally_and_finish();
  end
endmodule : pipelined_burst_sram_port_tb
